/* File: rtl/wit_top.sv */
// Purpose: Watchdog and interval timer with an APB register slave.
// Assumes: All inputs synchronous to sys_clk; APB3 signalling, zero wait states.
// Notes: Overflow outputs are registered one-cycle pulses.
`timescale 1ns/1ps
`include "wit_defines.svh"

module wit_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`WIT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt controller and power manager
	output logic overflow_irq,
	output logic guard_expired_out,
	output logic poweron_reset_out,
	output logic manual_reset_out
);
	import wit_pkg::*;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	wit_byte_t wdog_control_reg;
	wit_byte_t wdog_counter;
	logic [1:0] overflow_flag_reg;
	logic [`WIT_DIV_W-1:0] div_count;
	logic [`WIT_DIV_W-1:0] div_term;
	wit_prescale_e prescale_bits;
	logic irq_allow, mode_select, count_run, chip_reset_allow, reset_kind_select;
	logic setup_phase, access_phase, addr_hit;
	logic wr_control, wr_count, rd_flags;
	logic tick, overflow, guard_ovf, interval_ovf;

	// Control fields decoded from the control register.
	assign irq_allow = wdog_control_reg[`WIT_BIT_IRQ_ALLOW];
	assign mode_select = wdog_control_reg[`WIT_BIT_MODE_SELECT];
	assign count_run = wdog_control_reg[`WIT_BIT_COUNT_RUN];
	assign chip_reset_allow = wdog_control_reg[`WIT_BIT_CHIP_RESET_ALLOW];
	assign reset_kind_select = wdog_control_reg[`WIT_BIT_RESET_KIND];
	assign prescale_bits = wit_prescale_e'(wdog_control_reg[`WIT_PRESCALE_HI:`WIT_PRESCALE_LO]);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// Writes act in the access phase; reads are sampled and cleared in setup.
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign addr_hit = (paddr == `WIT_OFS_CONTROL) || (paddr == `WIT_OFS_FLAGS) ||
		(paddr == `WIT_OFS_COUNT);
	assign wr_control = access_phase && pwrite && (paddr == `WIT_OFS_CONTROL);
	assign wr_count = access_phase && pwrite && (paddr == `WIT_OFS_COUNT);
	assign rd_flags = setup_phase && !pwrite && (paddr == `WIT_OFS_FLAGS);
	assign pready = 1'b1;
	assign pslverr = access_phase && !addr_hit;

	// Read data is captured at the setup edge so the returned flags match the clear.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			case (paddr)
				`WIT_OFS_CONTROL: prdata <= {24'h00_0000, wdog_control_reg};
				`WIT_OFS_FLAGS: prdata <= {30'h0, overflow_flag_reg};
				`WIT_OFS_COUNT: prdata <= {24'h00_0000, wdog_counter};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control register; reset leaves the timer stopped.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wdog_control_reg <= `WIT_CONTROL_RESET;
		end else if (wr_control) begin
			wdog_control_reg <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	// Terminal count for the selected division ratio.
	always_comb begin
		case (prescale_bits)
			WIT_DIV_2: div_term = `WIT_DIV_TERM_0;
			WIT_DIV_8: div_term = `WIT_DIV_TERM_1;
			WIT_DIV_32: div_term = `WIT_DIV_TERM_2;
			WIT_DIV_64: div_term = `WIT_DIV_TERM_3;
			WIT_DIV_256: div_term = `WIT_DIV_TERM_4;
			WIT_DIV_512: div_term = `WIT_DIV_TERM_5;
			WIT_DIV_2048: div_term = `WIT_DIV_TERM_6;
			WIT_DIV_8192: div_term = `WIT_DIV_TERM_7;
			default: div_term = `WIT_DIV_TERM_0;
		endcase
	end

	// The divider idles at zero while stopped so the first period after start is whole.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_count <= '0;
		end else if (!count_run || (div_count >= div_term)) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + `WIT_DIV_W'(1);
		end
	end

	assign tick = count_run && (div_count >= div_term);

	// ------------------------------------------------------------------
	// Counter and overflow
	// ------------------------------------------------------------------
	// A software load wins over a count pulse in the same cycle.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wdog_counter <= `WIT_COUNT_RESET;
		end else if (wr_count) begin
			wdog_counter <= pwdata[7:0];
		end else if (tick) begin
			wdog_counter <= wdog_counter + 8'h01;
		end
	end

	assign overflow = tick && !wr_count && (wdog_counter == `WIT_COUNT_MAX);
	assign guard_ovf = overflow && mode_select;
	assign interval_ovf = overflow && !mode_select;

	// Flags: an overflow in the cycle of the clearing read still sets its flag.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			overflow_flag_reg <= `WIT_FLAGS_RESET;
		end else begin
			overflow_flag_reg[`WIT_BIT_GUARD_OVF] <= guard_ovf ||
				(overflow_flag_reg[`WIT_BIT_GUARD_OVF] && !rd_flags);
			overflow_flag_reg[`WIT_BIT_INTERVAL_OVF] <= interval_ovf ||
				(overflow_flag_reg[`WIT_BIT_INTERVAL_OVF] && !rd_flags);
		end
	end

	// Registered one-cycle pulses toward the interrupt controller and power manager.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			overflow_irq <= 1'b0;
			guard_expired_out <= 1'b0;
			poweron_reset_out <= 1'b0;
			manual_reset_out <= 1'b0;
		end else begin
			overflow_irq <= overflow && irq_allow;
			guard_expired_out <= guard_ovf;
			poweron_reset_out <= guard_ovf && chip_reset_allow && !reset_kind_select;
			manual_reset_out <= guard_ovf && chip_reset_allow && reset_kind_select;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_wrap_to_zero: assert property (overflow |=> wdog_counter == 8'h00)
		else $error("counter did not wrap to zero on overflow");
	a_count_step: assert property (tick && !wr_count |=>
		wdog_counter == $past(wdog_counter) + 8'h01)
		else $error("counter did not step on a prescaler pulse");
	a_freeze_stop: assert property (!count_run && !wr_count |=> $stable(wdog_counter))
		else $error("stopped counter changed");
	a_load_write: assert property (wr_count |=> wdog_counter == $past(pwdata[7:0]))
		else $error("counter write not loaded");
	a_irq_gate: assert property (overflow_irq |-> $past(irq_allow) && $past(overflow))
		else $error("interrupt without allowed overflow");
	a_irq_pulse: assert property (overflow_irq |=> !overflow_irq)
		else $error("interrupt longer than one cycle");
	a_interval_flag: assert property (interval_ovf |=>
		overflow_flag_reg[1] && !guard_expired_out)
		else $error("interval overflow did not set its flag");
	a_guard_flag: assert property (guard_ovf |=>
		overflow_flag_reg[0] && guard_expired_out)
		else $error("watchdog overflow did not set flag and expiry");
	a_chip_reset: assert property (guard_ovf && chip_reset_allow |=>
		(poweron_reset_out != manual_reset_out) &&
		(manual_reset_out == $past(reset_kind_select)))
		else $error("wrong chip reset kind");
	a_no_reset: assert property (guard_ovf && !chip_reset_allow |=>
		!poweron_reset_out && !manual_reset_out)
		else $error("chip reset while not allowed");
	a_read_clear: assert property (rd_flags && !overflow |=>
		overflow_flag_reg == 2'b00)
		else $error("flags not cleared by read");
	a_div_period: assert property (tick && prescale_bits == WIT_DIV_8 && count_run &&
		!wr_control |=> !tick [*7])
		else $error("divide by eight period wrong");

	// Masking: the allow bit alone decides whether an overflow reaches the interrupt.
	a_irq_masked: assert property (overflow && !irq_allow |=> !overflow_irq)
		else $error("masked overflow raised the interrupt");
	a_irq_interval: assert property (interval_ovf && irq_allow |=> overflow_irq)
		else $error("interval overflow gave no interrupt");
	a_irq_guard: assert property (guard_ovf && irq_allow |=> overflow_irq)
		else $error("watchdog overflow gave no interrupt");
	a_interval_quiet: assert property (interval_ovf |=>
		!poweron_reset_out && !manual_reset_out)
		else $error("interval overflow requested a chip reset");
	// Reset requests come only from an allowed watchdog expiry, one cycle each.
	a_reset_source: assert property (poweron_reset_out || manual_reset_out |->
		$past(guard_ovf) && $past(chip_reset_allow))
		else $error("chip reset without allowed watchdog expiry");
	a_expiry_mode: assert property (guard_expired_out |->
		$past(mode_select) && $past(count_run))
		else $error("expiry outside watchdog mode");
	a_poweron_pulse: assert property (poweron_reset_out |=> !poweron_reset_out)
		else $error("power-on request longer than one cycle");
	a_manual_pulse: assert property (manual_reset_out |=> !manual_reset_out)
		else $error("manual request longer than one cycle");
	a_expiry_pulse: assert property (guard_expired_out |=> !guard_expired_out)
		else $error("expiry longer than one cycle");
	a_flag_hold: assert property (!rd_flags && !overflow |=> $stable(overflow_flag_reg))
		else $error("flags changed without read or overflow");

	c_interval_ovf: cover property (interval_ovf ##1 overflow_irq);
	c_guard_poweron: cover property (poweron_reset_out);
	c_guard_manual: cover property (manual_reset_out);
	c_read_clear: cover property (overflow_flag_reg != 2'b00 ##1 rd_flags);
	c_div_slowest: cover property (tick && prescale_bits == WIT_DIV_8192);
endmodule

/* File: rtl/wit_defines.svh */
// Purpose: Offsets, field positions, reset values and divider counts of the watchdog timer.
// Assumes: Byte addresses on the peripheral bus, one aligned word per register.
// Notes: Definitions only.
// Operation
// - Mode-select bit 6 and count-run bit 5 both one give watchdog mode.
// - Mode-select zero with count-run one gives interval mode, interrupt per overflow; the code interrupts only when irq_allow is one.
// - Counter increments per prescaled pulse; overflow when 0xFF wraps to 0x00.
// - Watchdog overflow requests reset; interrupt only when irq_allow is one.
// - Chip-reset-allow bit 4 set makes watchdog overflow reset the chip.
// - Reset-kind bit 3: zero power-on reset, one manual reset.
// - Prescale codes 000..111 divide by 2,8,32,64,256,512,2048,8192.
// - Interval overflow sets status bit 1 and requests the interrupt; the code raises it only when irq_allow is one.
// - Watchdog overflow sets status bit 0 and pulses the expiry output.
// - Reading the status register returns the flags then clears them.
// - Reset clears both overflow flags.
// - Reset loads counter zero and control zero, timer stopped.
`ifndef WIT_DEFINES_SVH
`define WIT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WIT_ADDR_W 16
`define WIT_OFS_CONTROL 16'h1100
`define WIT_OFS_FLAGS 16'h1104
`define WIT_OFS_COUNT 16'h1108

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define WIT_BIT_IRQ_ALLOW 7
`define WIT_BIT_MODE_SELECT 6
`define WIT_BIT_COUNT_RUN 5
`define WIT_BIT_CHIP_RESET_ALLOW 4
`define WIT_BIT_RESET_KIND 3
`define WIT_PRESCALE_HI 2
`define WIT_PRESCALE_LO 0
`define WIT_BIT_GUARD_OVF 0
`define WIT_BIT_INTERVAL_OVF 1
`define WIT_CONTROL_RESET 8'h00
`define WIT_COUNT_RESET 8'h00
`define WIT_FLAGS_RESET 2'h0
`define WIT_COUNT_MAX 8'hFF

// ----------------------------------------------------------------------
// Divider terminal counts (divide ratio minus one), 13-bit
// ----------------------------------------------------------------------
`define WIT_DIV_W 13
`define WIT_DIV_TERM_0 13'h0001
`define WIT_DIV_TERM_1 13'h0007
`define WIT_DIV_TERM_2 13'h001F
`define WIT_DIV_TERM_3 13'h003F
`define WIT_DIV_TERM_4 13'h00FF
`define WIT_DIV_TERM_5 13'h01FF
`define WIT_DIV_TERM_6 13'h07FF
`define WIT_DIV_TERM_7 13'h1FFF

`endif

/* File: rtl/wit_pkg.sv */
// Purpose: Types shared by the watchdog timer.
// Assumes: Constants come from the defines header.
// Notes: Prescale codes in ascending divide order.
package wit_pkg;
	typedef enum logic [2:0] {
		WIT_DIV_2 = 3'b000,
		WIT_DIV_8 = 3'b001,
		WIT_DIV_32 = 3'b010,
		WIT_DIV_64 = 3'b011,
		WIT_DIV_256 = 3'b100,
		WIT_DIV_512 = 3'b101,
		WIT_DIV_2048 = 3'b110,
		WIT_DIV_8192 = 3'b111
	} wit_prescale_e;
	typedef logic [7:0] wit_byte_t;
endpackage

/* File: testbench/wit_pmu_model.sv */
// Purpose: Receiver model of the interrupt controller and power manager.
// Assumes: Requests are active-high pulses synchronous to sys_clk.
// Notes: Counts each request and every cycle that a request stays high too long.
`timescale 1ns/1ps

module wit_pmu_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Requests: manual reset, power-on reset, expiry, interrupt
	input wire logic [3:0] pulses,
	// Request counts and over-long pulse cycles
	output logic [3:0][7:0] hits,
	output logic [7:0] stretched
);
	logic [3:0] prev;

	// Count rising edges per request; a request high on two cycles in a row is a fault.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hits <= '0;
			stretched <= 8'h00;
			prev <= 4'h0;
		end else begin
			prev <= pulses;
			for (int k = 0; k < 4; k++) begin
				if (pulses[k] && !prev[k]) hits[k] <= hits[k] + 8'h01;
			end
			if (|(pulses & prev)) stretched <= stretched + 8'h01;
		end
	end
endmodule

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the watchdog and interval timer.
// Assumes: Zero-wait register bus; divider ratios as in the prescale table.
// Notes: The prescale timing check demands the exact cycle count, with no slack.
`timescale 1ns/1ps
`include "wit_defines.svh"

module tb;
	import wit_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, v;
	logic pready, pslverr, err_bit, rdy;
	logic overflow_irq, guard_expired_out, poweron_reset_out, manual_reset_out;
	logic [3:0][7:0] hits, base;
	logic [7:0] stretched;
	int err_total = 0;
	int n_checks = 0;
	int cyc;
	int div [8] = '{2, 8, 32, 64, 256, 512, 2048, 8192};
	wit_byte_t ctl [6] = '{8'hE0, 8'h60, 8'hF0, 8'hF8, 8'h20, 8'hB0};
	logic [5:0] exp [6] = '{6'h13, 6'h12, 6'h17, 6'h1B, 6'h20, 6'h21};

	// Clock of 5 ns period.
	always #2.5 sys_clk = ~sys_clk;

	wit_top u_wit_top (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .overflow_irq(overflow_irq), .guard_expired_out(guard_expired_out),
		.poweron_reset_out(poweron_reset_out), .manual_reset_out(manual_reset_out));
	wit_pmu_model u_wit_pmu_model (.sys_clk(sys_clk), .reset(reset),
		.pulses({manual_reset_out, poweron_reset_out, guard_expired_out, overflow_irq}),
		.hits(hits), .stretched(stretched));

	task check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	// One setup and one access cycle; read data and error taken at the completing edge.
	task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err_bit = pslverr;
		rdy = pready;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task conclude;
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Watchdog against a hang, well beyond the expected run.
	initial begin
		#200000;
		err_total++;
		conclude();
	end

	// Main sequence of tests.
	initial begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		apb(0, `WIT_OFS_CONTROL, 0); check(rd, 32'h0);
		check(32'(rdy), 32'h1);
		check(32'(err_bit), 32'h0);
		apb(0, `WIT_OFS_COUNT, 0); check(rd, 32'h0);
		apb(0, `WIT_OFS_FLAGS, 0); check(rd, 32'h0);
		apb(0, 16'h110C, 0); check(32'(err_bit), 32'h1);
		apb(1, `WIT_OFS_CONTROL, 32'hABCD001D); apb(0, `WIT_OFS_CONTROL, 0); check(rd, 32'h1D);
		$display("test reset and access done");
		base = hits;
		for (int c = 0; c < 8; c++) begin
			apb(1, `WIT_OFS_COUNT, 32'hFF);
			apb(1, `WIT_OFS_CONTROL, 32'hA0 | c);
			cyc = 0;
			while (overflow_irq !== 1'b1 && cyc < 9000) begin
				@(negedge sys_clk);
				cyc++;
			end
			check(32'(cyc), 32'(div[c] + 1));
			apb(1, `WIT_OFS_CONTROL, 0);
			apb(0, `WIT_OFS_FLAGS, 0); check(rd, 32'h2);
			apb(0, `WIT_OFS_FLAGS, 0); check(rd, 32'h0);
		end
		check(32'(hits[0] - base[0]), 32'h8);
		$display("test prescale done");
		for (int i = 0; i < 6; i++) begin
			base = hits;
			apb(1, `WIT_OFS_COUNT, 32'hFF);
			apb(1, `WIT_OFS_CONTROL, 32'(ctl[i]));
			repeat (10) @(posedge sys_clk);
			apb(1, `WIT_OFS_CONTROL, 0);
			for (int k = 0; k < 4; k++) begin
				check(32'(hits[k] - base[k]), 32'(exp[i][k]));
			end
			apb(0, `WIT_OFS_FLAGS, 0); check(rd, 32'(exp[i][5:4]));
		end
		$display("test modes done");
		base = hits;
		apb(1, `WIT_OFS_COUNT, 0);
		apb(1, `WIT_OFS_CONTROL, 32'hE0);
		for (int j = 0; j < 4; j++) begin
			repeat (100) @(posedge sys_clk);
			apb(1, `WIT_OFS_COUNT, 0);
		end
		apb(1, `WIT_OFS_COUNT, 32'h40);
		repeat (20) @(posedge sys_clk);
		apb(1, `WIT_OFS_CONTROL, 0);
		check(32'(hits[1] - base[1]), 32'h0);
		apb(0, `WIT_OFS_COUNT, 0);
		v = rd;
		check(v, 32'h4C);
		repeat (20) @(posedge sys_clk);
		apb(0, `WIT_OFS_COUNT, 0); check(rd, v);
		check(32'(stretched), 32'h0);
		$display("test service and freeze done");
		apb(1, `WIT_OFS_CONTROL, 32'hE7);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		apb(0, `WIT_OFS_CONTROL, 0); check(rd, 32'h0);
		apb(0, `WIT_OFS_COUNT, 0); check(rd, 32'h0);
		apb(0, `WIT_OFS_FLAGS, 0); check(rd, 32'h0);
		$display("test mid-run reset done");
		conclude();
	end
endmodule
